/* File: rtl/tvga_top.sv */
// terminal video gate array: clocking, dots, attributes, fonts
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/100ps
`include "tvga_params.svh"
module tvga_top (
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  // register port
  input wire logic [3:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [15:0] REG_RDATA_O,
  // row buffer character stream
  input wire logic [15:0] CHR_DATA_I,
  input wire logic CHR_VALID_I,
  output logic CHR_READY_O,
  // asynchronous pins
  input wire logic HSYNC_I,
  input wire logic VSYNC_I,
  input wire logic BLANK_I,
  input wire logic DISPLAY_BUS_REQUEST_I,
  input wire logic COL132_I,
  input wire logic BUS_FREE_I,
  input wire logic CPU_REQ_I,
  input wire logic [12:0] CPU_ADDR_I,
  input wire logic [12:0] VID_ADDR_I,
  input wire logic [7:0] FONT_Q_I,
  // outputs
  output logic CHARACTER_CLOCK_O,
  output logic VIDEO_O,
  output logic BRIGHT_O,
  output logic DBL_HIGH_O,
  output logic DBL_WIDE_O,
  output logic [1:0] FONT_SEL_O,
  output logic [12:0] FONT_ADDR_O,
  output logic [7:0] FONT_DATA_O,
  output logic FONT_WE_O,
  output logic BEEP_O,
  output logic CHAR_BLINK_O,
  output logic CURSOR_BLINK_O,
  output logic [12:0] MEM_ADDR_O,
  output logic MEM_VIDEO_O,
  output logic CHAR_CS_O,
  output logic ATTR_CS_O
);
  tvga_pkg::tvga_pin_s pin_raw; // gathered pins
  tvga_pkg::tvga_pin_s pin_meta_q; // first sync stage
  tvga_pkg::tvga_pin_s pin_q; // second sync stage
  tvga_pkg::tvga_chr_s fifo_out; // head of fifo
  tvga_pkg::tvga_font_s font_d; // next font port value
  logic fifo_valid; // fifo has a character
  logic fifo_pop; // take one character
  logic hs_q; // delayed hsync
  logic vs_q; // delayed vsync
  logic hs_rise; // hsync edge
  logic vs_rise; // vsync edge
  logic [3:0] div_q; // dot counter within character
  logic [3:0] div_last; // terminal count
  logic char_tick; // last dot of a character
  logic [7:0] shift_q; // dot shifter
  logic dot; // raw dot after blink
  logic dot_prev_q; // previous dot for stretching
  logic [7:0] attr_next_q; // attribute of fetched char
  logic [7:0] attr_cur_q; // attribute of shown char
  logic valid_next_q; // fetched slot holds a char
  logic valid_cur_q; // shown slot holds a char
  logic [3:0] line_q; // scan line counter
  logic [3:0] scroll_q; // scan line preset
  logic [3:0] lines_q; // last scan line of row
  logic beep_en_q; // beeper enable
  logic [4:0] beep_cnt_q; // hsync count
  logic beep_ph_q; // beeper tone phase
  logic [5:0] frame_q; // frame counter for blink
  logic [12:0] faddr_q; // font load address
  logic load_done_q; // font memory filled
  logic [12:0] vaddr_q; // held display address
  logic [15:0] rdata_d; // read mux

  // gather pins into one carrier
  assign pin_raw = '{hsync: HSYNC_I, vsync: VSYNC_I, blank: BLANK_I,
                     dbreq: DISPLAY_BUS_REQUEST_I, col132: COL132_I,
                     bus_free: BUS_FREE_I, cpu_req: CPU_REQ_I,
                     cpu_addr: CPU_ADDR_I, vid_addr: VID_ADDR_I,
                     font_q: FONT_Q_I};

  // two-stage synchroniser for every pin
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      pin_meta_q <= '0;
      pin_q <= '0;
    end
    else
    begin
      pin_meta_q <= pin_raw;
      pin_q <= pin_meta_q;
    end
  end

  // edge detect on synchronised syncs
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      hs_q <= 1'b0;
      vs_q <= 1'b0;
    end
    else
    begin
      hs_q <= pin_q.hsync;
      vs_q <= pin_q.vsync;
    end
  end
  assign hs_rise = pin_q.hsync & ~hs_q;
  assign vs_rise = pin_q.vsync & ~vs_q;

  // R4 column select level
  // R2 divisor by column mode
  assign div_last = pin_q.col132 ? (`TVGA_DIV_132 - 4'h1)
                                 : (`TVGA_DIV_80 - 4'h1);
  assign char_tick = (div_q >= div_last);

  // dot counter, one dot per reference clock
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      div_q <= 4'h0;
    else if (char_tick)
      div_q <= 4'h0;
    else
      div_q <= div_q + 4'h1;
  end

  // R2 character clock output
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      CHARACTER_CLOCK_O <= 1'b0;
    else if (char_tick)
      CHARACTER_CLOCK_O <= 1'b1;
    else
      CHARACTER_CLOCK_O <= (div_q < {1'b0, div_last[3:1]});
  end

  // character stream buffer
  tvga_fifo #(
    .WIDTH(16),
    .DEPTH(`TVGA_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(REF_CLK_I),
    .nrst_i(NRST_I),
    .in_data_i(CHR_DATA_I),
    .in_valid_i(CHR_VALID_I),
    .in_ready_o(CHR_READY_O),
    .out_data_o(fifo_out),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );
  // R13 no fetch until fonts loaded
  assign fifo_pop = char_tick & load_done_q;

  // R9 attribute latches, fetch then show
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      attr_next_q <= 8'h00;
      attr_cur_q <= 8'h00;
      valid_next_q <= 1'b0;
      valid_cur_q <= 1'b0;
    end
    else if (char_tick)
    begin
      attr_next_q <= fifo_out.attr;
      valid_next_q <= fifo_valid & load_done_q;
      attr_cur_q <= attr_next_q;
      valid_cur_q <= valid_next_q;
    end
  end

  // R9 attribute outputs for shown char
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      BRIGHT_O <= 1'b0;
      DBL_HIGH_O <= 1'b0;
      DBL_WIDE_O <= 1'b0;
    end
    else
    begin
      BRIGHT_O <= attr_cur_q[`TVGA_ATTR_BRIGHT] & valid_cur_q;
      DBL_HIGH_O <= attr_cur_q[`TVGA_ATTR_DHIGH] & valid_cur_q;
      DBL_WIDE_O <= attr_cur_q[`TVGA_ATTR_DWIDE] & valid_cur_q;
    end
  end

  // R6 load once per character, MSB out first
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      shift_q <= 8'h00;
    // R5 pattern from character generator
    else if (char_tick)
      shift_q <= valid_next_q ? pin_q.font_q : 8'h00;
    else
      shift_q <= {shift_q[6:0], 1'b0};
  end

  // blink attribute suppresses dots in the off phase
  assign dot = shift_q[7] &
               ~(attr_cur_q[`TVGA_ATTR_BLINK] & ~CHAR_BLINK_O);

  // R7 stretch each dot by one dot time
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      dot_prev_q <= 1'b0;
    else
      dot_prev_q <= dot;
  end

  // video driver with blanking
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      VIDEO_O <= 1'b0;
    // R8 blank forces video off
    else if (pin_q.blank || !load_done_q)
      VIDEO_O <= 1'b0;
    else
      // R7 stretched dot
      VIDEO_O <= dot | dot_prev_q;
  end

  // R10 scan line counter with preset
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      line_q <= `TVGA_SCROLL_RST;
    else if (vs_rise)
      line_q <= scroll_q;
    else if (hs_rise)
      line_q <= (line_q >= lines_q) ? 4'h0 : line_q + 4'h1;
  end

  // R1 beeper: toggle every ten hsyncs
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      beep_cnt_q <= 5'h00;
      beep_ph_q <= 1'b0;
      BEEP_O <= 1'b0;
    end
    else
    begin
      if (hs_rise)
      begin
        if (beep_cnt_q == `TVGA_BEEP_HALF - 5'h01)
        begin
          beep_cnt_q <= 5'h00;
          beep_ph_q <= ~beep_ph_q;
        end
        else
          beep_cnt_q <= beep_cnt_q + 5'h01;
      end
      BEEP_O <= beep_en_q & beep_ph_q;
    end
  end

  // R11 frame counter drives two blink rates
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      frame_q <= 6'h00;
      CHAR_BLINK_O <= 1'b0;
      CURSOR_BLINK_O <= 1'b0;
    end
    else
    begin
      if (vs_rise)
        frame_q <= frame_q + 6'h01;
      CHAR_BLINK_O <= frame_q[`TVGA_BLINK_CHAR_BIT];
      CURSOR_BLINK_O <= frame_q[`TVGA_BLINK_CURS_BIT];
    end
  end

  // font port: loader while filling, lookup after
  always_comb
  begin
    font_d = '{addr: FONT_ADDR_O, data: FONT_DATA_O, we: 1'b0};
    if (!load_done_q)
    begin
      // R13 software words written in order
      if (REG_WR_I && REG_ADDR_I == `TVGA_REG_FDATA)
        font_d = '{addr: faddr_q, data: REG_WDATA_I[7:0], we: 1'b1};
    end
    else if (char_tick)
      // R12 two attribute bits choose font
      font_d.addr = {fifo_out.attr[`TVGA_ATTR_FONT_LO+1 -:2],
                     fifo_out.code[6:0], line_q};
  end

  // font port registers
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      FONT_ADDR_O <= 13'h0000;
      FONT_DATA_O <= 8'h00;
      FONT_WE_O <= 1'b0;
      FONT_SEL_O <= 2'h0;
    end
    else
    begin
      FONT_ADDR_O <= font_d.addr;
      FONT_DATA_O <= font_d.data;
      FONT_WE_O <= font_d.we;
      // R12 font select follows shown char
      FONT_SEL_O <= attr_cur_q[`TVGA_ATTR_FONT_LO+1 -:2];
    end
  end

  // R13 load address and done flag
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      faddr_q <= 13'h0000;
      load_done_q <= 1'b0;
    end
    else if (REG_WR_I && REG_ADDR_I == `TVGA_REG_CTRL &&
             REG_WDATA_I[`TVGA_CTRL_RELOAD])
    begin
      faddr_q <= 13'h0000;
      load_done_q <= 1'b0;
    end
    else if (!load_done_q && REG_WR_I)
    begin
      if (REG_ADDR_I == `TVGA_REG_FADDR)
        faddr_q <= REG_WDATA_I[12:0];
      else if (REG_ADDR_I == `TVGA_REG_FDATA)
      begin
        faddr_q <= faddr_q + 13'h0001;
        if (faddr_q == 13'h1fff)
          load_done_q <= 1'b1;
      end
    end
  end

  // software control registers
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      beep_en_q <= 1'b0;
      scroll_q <= `TVGA_SCROLL_RST;
      lines_q <= `TVGA_LINES_RST;
    end
    else if (REG_WR_I)
    begin
      unique case (REG_ADDR_I)
        `TVGA_REG_CTRL: beep_en_q <= REG_WDATA_I[`TVGA_CTRL_BEEP];
        `TVGA_REG_SCROLL: scroll_q <= REG_WDATA_I[3:0];
        `TVGA_REG_LINES: lines_q <= REG_WDATA_I[3:0];
        default: ;
      endcase
    end
  end

  // read mux; unmapped reads zero
  always_comb
  begin
    rdata_d = 16'h0000;
    unique case (REG_ADDR_I)
      `TVGA_REG_CTRL: rdata_d = {15'h0000, beep_en_q};
      `TVGA_REG_SCROLL: rdata_d = {12'h000, scroll_q};
      `TVGA_REG_LINES: rdata_d = {12'h000, lines_q};
      `TVGA_REG_FADDR: rdata_d = {3'h0, faddr_q};
      `TVGA_REG_STATUS: rdata_d = {8'h00, line_q, 2'h0,
                                   pin_q.col132, load_done_q};
      default: rdata_d = 16'h0000;
    endcase
  end

  // read data one cycle after strobe only
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      REG_RDATA_O <= 16'h0000;
    else
      REG_RDATA_O <= REG_RD_I ? rdata_d : 16'h0000;
  end

  // R14 hold display address until request
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      vaddr_q <= 13'h0000;
    else if (!pin_q.dbreq)
      vaddr_q <= pin_q.vid_addr;
  end

  // display memory address drive
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      MEM_ADDR_O <= 13'h0000;
      MEM_VIDEO_O <= 1'b0;
      CHAR_CS_O <= 1'b0;
      ATTR_CS_O <= 1'b0;
    end
    // R14 drive held address once bus free
    else if (pin_q.dbreq && pin_q.bus_free)
    begin
      MEM_ADDR_O <= vaddr_q;
      MEM_VIDEO_O <= 1'b1;
      CHAR_CS_O <= 1'b1;
      ATTR_CS_O <= 1'b1;
    end
    else
    begin
      MEM_ADDR_O <= pin_q.cpu_addr;
      MEM_VIDEO_O <= 1'b0;
      // R16 attribute selected with character
      CHAR_CS_O <= pin_q.cpu_req;
      ATTR_CS_O <= pin_q.cpu_req;
    end
  end
endmodule

/* File: rtl/tvga_params.svh */
// constants of the terminal video gate array
// What this block does
// R1 - beeper tone is hsync rate over 20
// R2 - character clock: divide 9 or 10
// R3 - processor picks dot clock oscillator; not done here, dots always run on REF_CLK_I
// R4 - select low 80 columns, high 132
// R5 - serialise 8-bit character generator pattern
// R6 - load per character, shift MSB first
// R7 - stretch each dot's on time
// R8 - blank input forces video off
// R9 - latch per-character screen and row attributes
// R10 - presettable scan line counter for scrolling
// R11 - separate blink timing for characters, cursor
// R12 - two attribute bits pick font
// R13 - write font memory before display starts
// R14 - hold display address until bus request
// R15 - timing controller raises bus request first
// R16 - character access also addresses attribute
`ifndef TVGA_PARAMS_SVH
`define TVGA_PARAMS_SVH
// register offsets
`define TVGA_REG_CTRL 4'h0
`define TVGA_REG_SCROLL 4'h1
`define TVGA_REG_LINES 4'h2
`define TVGA_REG_FADDR 4'h3
`define TVGA_REG_FDATA 4'h4
`define TVGA_REG_STATUS 4'h5
// control field positions
`define TVGA_CTRL_BEEP 0
`define TVGA_CTRL_RELOAD 1
// attribute byte field positions
`define TVGA_ATTR_FONT_LO 0
`define TVGA_ATTR_BRIGHT 2
`define TVGA_ATTR_BLINK 3
`define TVGA_ATTR_DHIGH 4
`define TVGA_ATTR_DWIDE 5
// reset values
`define TVGA_LINES_RST 4'hb
`define TVGA_SCROLL_RST 4'h0
// timing counts
`define TVGA_DIV_132 4'h9
`define TVGA_DIV_80 4'ha
`define TVGA_BEEP_HALF 5'h0a
`define TVGA_BLINK_CHAR_BIT 5
`define TVGA_BLINK_CURS_BIT 4
`define TVGA_FIFO_DEPTH 8
`endif

/* File: rtl/tvga_pkg.sv */
// types shared by the terminal video gate array
package tvga_pkg;
  // one row-buffer entry: attribute and character code
  typedef struct packed {
    logic [7:0] attr;
    logic [7:0] code;
  } tvga_chr_s;
  // pins from outside the clock domain
  typedef struct packed {
    logic hsync;
    logic vsync;
    logic blank;
    logic dbreq;
    logic col132;
    logic bus_free;
    logic cpu_req;
    logic [12:0] cpu_addr;
    logic [12:0] vid_addr;
    logic [7:0] font_q;
  } tvga_pin_s;
  // font memory write/read port
  typedef struct packed {
    logic [12:0] addr;
    logic [7:0] data;
    logic we;
  } tvga_font_s;
endpackage

/* File: rtl/tvga_fifo.sv */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module tvga_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  // handshakes on each side
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem_q[rd_q];
  // storage write
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_q[wr_q] <= in_data_i;
  end
  // pointers and fill level
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
  // full and empty from a registered level
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end
    else
    begin
      if (push && !pop)
      begin
        in_ready_o <= (cnt_q != (AW+1)'(DEPTH - 1));
        out_valid_o <= 1'b1;
      end
      else if (pop && !push)
      begin
        in_ready_o <= 1'b1;
        out_valid_o <= (cnt_q != (AW+1)'(1));
      end
    end
  end
endmodule

/* File: bench/tvga_top_assertions.sv */
// port checker for the terminal video gate array
`timescale 1ns/100ps
module tvga_assert_chk (
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic [3:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic BLANK_I,
  input wire logic DISPLAY_BUS_REQUEST_I,
  input wire logic COL132_I,
  input wire logic BUS_FREE_I,
  input wire logic CPU_REQ_I,
  input wire logic [12:0] CPU_ADDR_I,
  input wire logic CHARACTER_CLOCK_O,
  input wire logic VIDEO_O,
  input wire logic [12:0] FONT_ADDR_O,
  input wire logic [7:0] FONT_DATA_O,
  input wire logic FONT_WE_O,
  input wire logic BEEP_O,
  input wire logic [12:0] MEM_ADDR_O,
  input wire logic MEM_VIDEO_O,
  input wire logic CHAR_CS_O,
  input wire logic ATTR_CS_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);
  logic cc_q, seen_q, col_q, beep_en_q;
  logic [4:0] gap_q, age_q;
  // rise of the divided clock and low write byte
  wire logic cc_rise = CHARACTER_CLOCK_O & ~cc_q;
  wire logic [7:0] wd_lo = REG_WDATA_I[7:0];
  // gap between clock rises, age of the column mode
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      cc_q <= 1'h0;
      seen_q <= 1'h0;
      col_q <= 1'h0;
      gap_q <= 5'h00;
      age_q <= 5'h00;
    end
    else
    begin
      cc_q <= CHARACTER_CLOCK_O;
      seen_q <= seen_q | cc_rise;
      col_q <= COL132_I;
      gap_q <= cc_rise ? 5'h01 : gap_q + {4'h0, gap_q != 5'h1f};
      age_q <= (COL132_I != col_q) ? 5'h00 : age_q + {4'h0, age_q != 5'h1f};
    end
  end
  // shadow of the beep enable bit
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      beep_en_q <= 1'h0;
    else if (REG_WR_I && REG_ADDR_I == 4'h0)
      beep_en_q <= REG_WDATA_I[0];
  end
  sequence s_grant;
    (DISPLAY_BUS_REQUEST_I && BUS_FREE_I) [*6];
  endsequence
  sequence s_cpu;
    (!DISPLAY_BUS_REQUEST_I && CPU_REQ_I && $stable(CPU_ADDR_I)) [*6];
  endsequence
  sequence s_lit;
    (!BLANK_I) [*5] ##0 $rose(VIDEO_O);
  endsequence
  property p_div;
    cc_rise && seen_q && age_q == 5'h1f |-> gap_q == (COL132_I ? 5'h09 : 5'h0a);
  endproperty
  a_div: assert property (p_div)
    else $error("character clock period wrong");
  property p_blank;
    BLANK_I [*5] |-> !VIDEO_O;
  endproperty
  a_blank: assert property (p_blank)
    else $error("video lit during blanking");
  property p_stretch;
    s_lit |=> VIDEO_O;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("dot not stretched");
  property p_font_we;
    FONT_WE_O |-> $past(REG_WR_I) && $past(REG_ADDR_I) == 4'h4
      && FONT_DATA_O == $past(wd_lo);
  endproperty
  a_font_we: assert property (p_font_we)
    else $error("font write without data write");
  property p_addr_inc;
    FONT_WE_O && $past(FONT_WE_O) |-> FONT_ADDR_O == $past(FONT_ADDR_O) + 13'h1;
  endproperty
  a_addr_inc: assert property (p_addr_inc)
    else $error("font address not stepped");
  property p_beep_off;
    !beep_en_q [*3] |-> !BEEP_O;
  endproperty
  a_beep_off: assert property (p_beep_off)
    else $error("beeper sounds while disabled");
  property p_mem_vid;
    s_grant |-> MEM_VIDEO_O && CHAR_CS_O;
  endproperty
  a_mem_vid: assert property (p_mem_vid)
    else $error("display access not granted");
  property p_hold;
    s_grant ##1 (DISPLAY_BUS_REQUEST_I && BUS_FREE_I) |-> $stable(MEM_ADDR_O);
  endproperty
  a_hold: assert property (p_hold)
    else $error("held display address moved");
  property p_cpu_path;
    s_cpu |-> MEM_ADDR_O == CPU_ADDR_I && CHAR_CS_O && !MEM_VIDEO_O;
  endproperty
  a_cpu_path: assert property (p_cpu_path)
    else $error("processor address not passed");
  property p_cs_pair;
    CHAR_CS_O == ATTR_CS_O;
  endproperty
  a_cs_pair: assert property (p_cs_pair)
    else $error("attribute select not paired");
endmodule
bind tvga_top tvga_assert_chk u_chk (.REF_CLK_I, .NRST_I, .REG_ADDR_I,
  .REG_WDATA_I, .REG_WR_I, .BLANK_I, .DISPLAY_BUS_REQUEST_I, .COL132_I,
  .BUS_FREE_I, .CPU_REQ_I, .CPU_ADDR_I, .CHARACTER_CLOCK_O, .VIDEO_O,
  .FONT_ADDR_O, .FONT_DATA_O, .FONT_WE_O, .BEEP_O, .MEM_ADDR_O,
  .MEM_VIDEO_O, .CHAR_CS_O, .ATTR_CS_O);

/* File: bench/tvga_far_model.sv */
// font memory and line sync source beside the gate array
`timescale 1ns/100ps
module tvga_far_model #(
  parameter int HS_PERIOD = 8
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [12:0] font_addr_i,
  input wire logic [7:0] font_data_i,
  input wire logic font_we_i,
  output logic [7:0] font_q_o,
  input wire logic hs_run_i,
  output logic hsync_o
);
  logic [7:0] font_mem [0:8191];
  logic [7:0] hs_cnt_q;
  // font memory storage, cleared at start
  initial for (int i = 0; i < 8192; i++) font_mem[i] = 8'h00;
  // plain always: the array is also cleared by the initial above
  always @(posedge clk_i)
  begin
    if (font_we_i)
      font_mem[font_addr_i] <= font_data_i;
  end
  // one cycle read latency
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      font_q_o <= 8'h00;
    else
      font_q_o <= font_mem[font_addr_i];
  end
  // line sync: two cycles high each period while running
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      hs_cnt_q <= 8'h00;
      hsync_o <= 1'h0;
    end
    else
    begin
      hs_cnt_q <= (hs_cnt_q == 8'(HS_PERIOD - 1)) ? 8'h00 : hs_cnt_q + 8'h01;
      hsync_o <= hs_run_i && hs_cnt_q < 8'h02;
    end
  end
endmodule

/* File: bench/tvga_top_bench.sv */
// self-checking bench for the terminal video gate array
`timescale 1ns/100ps
module tvga_top_bench;
  logic REF_CLK_I = 1'h0, NRST_I = 1'h0, REG_WR_I = 1'h0, REG_RD_I = 1'h0;
  logic CHR_VALID_I = 1'h0, VSYNC_I = 1'h0, BLANK_I = 1'h0, COL132_I = 1'h0;
  logic DISPLAY_BUS_REQUEST_I = 1'h0, BUS_FREE_I = 1'h0, CPU_REQ_I = 1'h0;
  logic [3:0] REG_ADDR_I = 4'h0;
  logic [15:0] REG_WDATA_I = 16'h0, CHR_DATA_I = 16'h0, REG_RDATA_O;
  logic [12:0] CPU_ADDR_I = 13'h0, VID_ADDR_I = 13'h0, FONT_ADDR_O, MEM_ADDR_O;
  logic [7:0] FONT_Q_I, FONT_DATA_O;
  logic [1:0] FONT_SEL_O;
  logic HSYNC_I, CHR_READY_O, CHARACTER_CLOCK_O, VIDEO_O, BRIGHT_O, BEEP_O;
  logic DBL_HIGH_O, DBL_WIDE_O, FONT_WE_O, CHAR_BLINK_O, CURSOR_BLINK_O;
  logic MEM_VIDEO_O, CHAR_CS_O, ATTR_CS_O, hs_run = 1'h0;
  int n_fail = 0, comparisons = 0;
  tvga_top DUT (.*);
  tvga_far_model u_far (.clk_i(REF_CLK_I), .nrst_i(NRST_I),
    .font_addr_i(FONT_ADDR_O), .font_data_i(FONT_DATA_O),
    .font_we_i(FONT_WE_O), .font_q_o(FONT_Q_I), .hs_run_i(hs_run),
    .hsync_o(HSYNC_I));
  // 100 MHz dot clock
  always #5 REF_CLK_I = ~REF_CLK_I;
  task chk(input logic [15:0] got, input logic [15:0] exp, input string s);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t %s: got %h want %h", $time, s, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge REF_CLK_I);
  endtask
  // one-cycle register write
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge REF_CLK_I);
    REG_WR_I <= 1'h1;
    REG_ADDR_I <= a;
    REG_WDATA_I <= d;
    @(posedge REF_CLK_I);
    REG_WR_I <= 1'h0;
  endtask
  // read strobe, data taken in the following cycle
  task rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge REF_CLK_I);
    REG_RD_I <= 1'h1;
    REG_ADDR_I <= a;
    @(posedge REF_CLK_I);
    REG_RD_I <= 1'h0;
    // data stands until this edge; taken before it is cleared
    @(posedge REF_CLK_I);
    d = REG_RDATA_O;
  endtask
  task t_reset;
    logic [15:0] d;
    rd(4'h2, d); chk(d, 16'h000b, "lines reset");
    rd(4'h1, d); chk(d, 16'h0000, "scroll reset");
    rd(4'h5, d); chk(d[0], 1'h0, "done at reset");
    $display("reset test over");
  endtask
  task t_clkdiv;
    time t0;
    logic [15:0] d;
    for (int m = 1; m >= 0; m--)
    begin
      COL132_I <= m[0];
      cyc(40);
      @(posedge CHARACTER_CLOCK_O);
      t0 = $time;
      @(posedge CHARACTER_CLOCK_O);
      chk(16'(($time - t0) / 10), m ? 16'h9 : 16'ha, "divisor");
      rd(4'h5, d); chk(d[1], m[0], "mode bit");
    end
    $display("divider test over");
  endtask
  // fill the fifo while display is held off
  task t_fill;
    int n;
    CHR_DATA_I <= 16'h377f;
    CHR_VALID_I <= 1'h1;
    n = 0;
    while (n < 8)
    begin
      @(posedge REF_CLK_I);
      if (CHR_READY_O === 1'h1) n++;
    end
    CHR_VALID_I <= 1'h0;
    cyc(2);
    chk(CHR_READY_O, 1'h0, "fifo full refuses");
    $display("fill test over");
  endtask
  // font 3, code 7f, line 0 holds 88; last write sets done
  task t_font;
    logic [15:0] d;
    wr(4'h3, 16'h1ff0);
    rd(4'h9, d); chk(d, 16'h0, "unmapped read");
    for (int i = 0; i < 16; i++)
    begin
      if (i == 2)
      begin
        chk(FONT_ADDR_O, 13'h1ff0, "font address");
        chk({FONT_WE_O, FONT_DATA_O}, 9'h188, "font data");
      end
      REG_WR_I <= 1'h1;
      REG_ADDR_I <= 4'h4;
      REG_WDATA_I <= (i == 0) ? 16'h0088 : 16'h0000;
      @(posedge REF_CLK_I);
    end
    REG_WR_I <= 1'h0;
    rd(4'h5, d); chk(d[0], 1'h1, "load done");
    wr(4'h4, 16'h0055);
    cyc(1);
    chk(FONT_WE_O, 1'h0, "write after done");
    $display("font test over");
  endtask
  task t_video;
    int i, n;
    logic [7:0] v;
    i = 0;
    do
    begin
      @(posedge REF_CLK_I);
      i++;
    end
    while (VIDEO_O !== 1'h1 && i < 400);
    chk({BRIGHT_O, DBL_HIGH_O, DBL_WIDE_O}, 3'h7, "attributes");
    chk(FONT_SEL_O, 2'h3, "font select");
    v[7] = VIDEO_O;
    for (i = 6; i >= 0; i--)
    begin
      @(posedge REF_CLK_I);
      v[i] = VIDEO_O;
    end
    chk(v, 8'hcc, "dot stream");
    BLANK_I <= 1'h1;
    CHR_VALID_I <= 1'h1;
    cyc(4);
    CHR_VALID_I <= 1'h0;
    n = 0;
    repeat (80)
    begin
      @(posedge REF_CLK_I);
      n += (VIDEO_O !== 1'h0);
    end
    chk(n[15:0], 16'h0, "blanked video");
    BLANK_I <= 1'h0;
    $display("video test over");
  endtask
  // sync period 80 ns, tone half period is ten syncs
  task t_beep;
    time t0;
    int n;
    wr(4'h0, 16'h0001);
    hs_run <= 1'h1;
    @(posedge BEEP_O);
    t0 = $time;
    @(negedge BEEP_O);
    chk(16'(($time - t0) / 80), 16'ha, "beep half period");
    wr(4'h0, 16'h0000);
    n = 0;
    repeat (200)
    begin
      @(posedge REF_CLK_I);
      #1 n += (BEEP_O !== 1'h0);
    end
    chk(n[15:0], 16'h0, "beep disabled");
    hs_run <= 1'h0;
    cyc(8);
    $display("beep test over");
  endtask
  task t_scroll;
    logic [15:0] d;
    wr(4'h1, 16'h0005);
    VSYNC_I <= 1'h1;
    cyc(4);
    VSYNC_I <= 1'h0;
    cyc(4);
    rd(4'h5, d); chk(d[7:4], 4'h5, "scan line preset");
    // frames 16 and 32: cursor phase bit 4, char phase bit 5
    for (int k = 1; k < 32; k++)
    begin
      VSYNC_I <= 1'h1;
      cyc(4);
      VSYNC_I <= 1'h0;
      cyc(4);
      if (k == 15 || k == 31)
        chk({CHAR_BLINK_O, CURSOR_BLINK_O}, (k == 15) ? 2'h1 : 2'h2, "blink");
    end
    $display("scroll test over");
  endtask
  task t_mem;
    VID_ADDR_I <= 13'h0123;
    cyc(5);
    DISPLAY_BUS_REQUEST_I <= 1'h1;
    cyc(4);
    VID_ADDR_I <= 13'h0456;
    BUS_FREE_I <= 1'h1;
    cyc(8);
    chk(MEM_ADDR_O, 13'h0123, "held address");
    chk({MEM_VIDEO_O, CHAR_CS_O, ATTR_CS_O}, 3'h7, "display access");
    DISPLAY_BUS_REQUEST_I <= 1'h0;
    BUS_FREE_I <= 1'h0;
    CPU_REQ_I <= 1'h1;
    CPU_ADDR_I <= 13'h0abc;
    cyc(8);
    chk(MEM_ADDR_O, 13'h0abc, "processor address");
    chk({MEM_VIDEO_O, CHAR_CS_O, ATTR_CS_O}, 3'h3, "paired selects");
    CPU_REQ_I <= 1'h0;
    $display("memory test over");
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence after 16 cycles of reset
  initial
  begin
    cyc(16);
    NRST_I <= 1'h1;
    t_reset;
    t_clkdiv;
    t_fill;
    t_font;
    t_video;
    t_beep;
    t_scroll;
    t_mem;
    final_report;
  end
  // watchdog, well beyond the thousand or so cycles needed
  initial
  begin
    cyc(20000);
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    final_report;
  end
endmodule
